// ---- hw/olap_pkg.sv ----
// Shared constants and types for the operand load / accumulate datapath.
// Assumes a single core clock; no bus-visible registers.
package olap_pkg;

    localparam int          OLAP_DATA_W     = 16;
    localparam int          OLAP_ADDR_W     = 16;
    localparam int          OLAP_ACC_W      = 32;
    localparam int          OLAP_DP_W       = 9;
    localparam int          OLAP_OFS_W      = 7;
    localparam int          OLAP_AUXP_W     = 3;

    // Product shift mode field inside flags word one
    localparam int          OLAP_PSM_LSB    = 0;
    localparam int          OLAP_PSM_W      = 2;
    localparam int          OLAP_SHL_ONE    = 1;
    localparam int          OLAP_SHL_FOUR   = 4;
    localparam int          OLAP_SHR_SIX    = 6;

    localparam logic [15:0] OLAP_FLAGS_RST  = 16'h0000;
    localparam logic [15:0] OLAP_FACTOR_RST = 16'h0000;
    localparam logic [31:0] OLAP_ACC_RST    = 32'h0000_0000;
    localparam logic [2:0]  OLAP_AUXP_RST   = 3'h0;

    typedef enum logic [2:0] {
        OLAP_OP_LOAD_FLAGS,
        OLAP_OP_LOAD_FLAGS_N,
        OLAP_OP_LOAD_FLAGS_ONE,
        OLAP_OP_LOAD_FACTOR,
        OLAP_OP_ACCUM_PREV,
        OLAP_OP_ACCUM_MOVE,
        OLAP_OP_PROD_TO_ACC
    } olap_op_e;

endpackage : olap_pkg

// ---- hw/olap_datapath.sv ----
// Load-instruction execution datapath: flags words, factor register, accumulator.
// Assumes decode, aux register arithmetic and the multiplier sit outside, on sys_clk_i.
//
// Functional notes
// - Status load writes the single flags word, or flags word zero on later parts.
// - Later parts: status load with selector writes the named flags word.
// - Later parts: dedicated second status load writes flags word one.
// - Operand load writes the memory word into the factor register.
// - Load-and-accumulate loads factor register and adds product into accumulator.
// - Later parts: product scaled by the shift mode field before accumulation.
// - Load-accumulate-move does load, accumulate and move as one instruction.
// - Load-accumulate-move writes the word to operand address plus one.
// - Later parts: transfer form loads factor register, accumulator takes product.
// - Operands addressed directly (page-relative) or indirectly, optional new aux pointer.
`timescale 1ns/1ps

module olap_datapath
    import olap_pkg::*;
#(
    parameter bit FIRST_GEN = 1'b0
) (
    input  wire logic                            sys_clk_i,
    input  wire logic                            sys_rst_i,
    input  wire logic                            op_valid_i,
    output logic                                 op_ready_o,
    input  wire olap_pkg::olap_op_e              op_code_i,
    input  wire logic                            op_flags_sel_i,
    input  wire logic                            op_indirect_i,
    input  wire logic [olap_pkg::OLAP_DP_W-1:0]   page_i,
    input  wire logic [olap_pkg::OLAP_OFS_W-1:0]  page_ofs_i,
    input  wire logic [olap_pkg::OLAP_ADDR_W-1:0] aux_addr_i,
    input  wire logic                            auxp_new_en_i,
    input  wire logic [olap_pkg::OLAP_AUXP_W-1:0] auxp_new_i,
    input  wire logic [olap_pkg::OLAP_ACC_W-1:0]  product_i,
    output logic                                 done_o,
    output logic                                 mem_rd_o,
    output logic [olap_pkg::OLAP_ADDR_W-1:0]      mem_rd_addr_o,
    input  wire logic [olap_pkg::OLAP_DATA_W-1:0] mem_rd_data_i,
    output logic                                 mem_wr_o,
    output logic [olap_pkg::OLAP_ADDR_W-1:0]      mem_wr_addr_o,
    output logic [olap_pkg::OLAP_DATA_W-1:0]      mem_wr_data_o,
    output logic [olap_pkg::OLAP_DATA_W-1:0]      flags_word_zero_o,
    output logic [olap_pkg::OLAP_DATA_W-1:0]      flags_word_one_o,
    output logic [olap_pkg::OLAP_DATA_W-1:0]      factor_reg_zero_o,
    output logic [olap_pkg::OLAP_ACC_W-1:0]       accum_o,
    output logic [olap_pkg::OLAP_AUXP_W-1:0]      aux_pointer_select_o
);
    import olap_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Product scaling by shift mode
    function automatic logic [OLAP_ACC_W-1:0] scale_product(
        input logic [OLAP_ACC_W-1:0] prod,
        input logic [OLAP_PSM_W-1:0] mode,
        input bit                    first_gen
    );
        logic [OLAP_ACC_W-1:0] res;
        res = prod;
        if (!first_gen) begin
            case (mode)
                2'h1:    res = prod << OLAP_SHL_ONE;
                2'h2:    res = prod << OLAP_SHL_FOUR;
                2'h3:    res = OLAP_ACC_W'($signed(prod) >>> OLAP_SHR_SIX);
                default: res = prod;
            endcase
        end
        return res;
    endfunction : scale_product

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: idle, memory fetch, apply
    typedef enum logic [1:0] {OLAP_S_IDLE, OLAP_S_FETCH, OLAP_S_APPLY} olap_state_e;

    olap_state_e               state;
    olap_state_e               next_state;
    olap_op_e                  cur_op;
    logic                      cur_sel;
    logic                      cur_ind;
    logic                      cur_auxp_en;
    logic [OLAP_AUXP_W-1:0]    cur_auxp;
    logic [OLAP_ADDR_W-1:0]    cur_addr;

    wire                       accept   = op_valid_i && (state == OLAP_S_IDLE);
    wire                       applying = (state == OLAP_S_APPLY);
    wire [OLAP_ADDR_W-1:0]     op_addr  = op_indirect_i ? aux_addr_i
                                                        : {page_i, page_ofs_i};
    wire [OLAP_PSM_W-1:0]      psm      = flags_word_one_o[OLAP_PSM_LSB +: OLAP_PSM_W];
    wire [OLAP_ACC_W-1:0]      scaled   = scale_product(product_i, psm, FIRST_GEN);

    // Instruction classes; later-generation forms write no flags, factor or accumulator on first-generation parts, but still set the aux pointer
    wire is_n     = (cur_op == OLAP_OP_LOAD_FLAGS_N) && !FIRST_GEN;
    wire wr_zero  = applying && ((cur_op == OLAP_OP_LOAD_FLAGS) || (is_n && !cur_sel));
    wire wr_one   = applying && (((cur_op == OLAP_OP_LOAD_FLAGS_ONE) && !FIRST_GEN)
                                 || (is_n && cur_sel));
    wire do_acc   = applying && ((cur_op == OLAP_OP_ACCUM_PREV)
                                 || (cur_op == OLAP_OP_ACCUM_MOVE));
    wire do_xfer  = applying && (cur_op == OLAP_OP_PROD_TO_ACC) && !FIRST_GEN;
    wire do_move  = applying && (cur_op == OLAP_OP_ACCUM_MOVE);
    wire wr_fact  = applying && ((cur_op == OLAP_OP_LOAD_FACTOR) || do_acc || do_xfer);
    wire set_auxp = applying && cur_ind && cur_auxp_en;

    assign op_ready_o    = (state == OLAP_S_IDLE);
    assign done_o        = applying;
    assign mem_rd_o      = (state == OLAP_S_FETCH);
    assign mem_rd_addr_o = cur_addr;

    always_comb begin
        case (state)
            OLAP_S_IDLE:  next_state = accept ? OLAP_S_FETCH : OLAP_S_IDLE;
            OLAP_S_FETCH: next_state = OLAP_S_APPLY;
            OLAP_S_APPLY: next_state = OLAP_S_IDLE;
            default:      next_state = OLAP_S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state      <= OLAP_S_IDLE;
            cur_op     <= OLAP_OP_LOAD_FLAGS;
            cur_sel    <= 1'b0;
            cur_ind    <= 1'b0;
            cur_auxp_en <= 1'b0;
            cur_auxp   <= OLAP_AUXP_RST;
            cur_addr   <= '0;
        end else begin
            state <= next_state;
            if (accept) begin
                cur_op     <= op_code_i;
                cur_sel    <= op_flags_sel_i;
                cur_ind    <= op_indirect_i;
                cur_auxp_en <= auxp_new_en_i;
                cur_auxp   <= auxp_new_i;
                cur_addr   <= op_addr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Architectural registers, written in the apply cycle
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            flags_word_zero_o    <= OLAP_FLAGS_RST;
            flags_word_one_o     <= OLAP_FLAGS_RST;
            factor_reg_zero_o    <= OLAP_FACTOR_RST;
            accum_o              <= OLAP_ACC_RST;
            aux_pointer_select_o <= OLAP_AUXP_RST;
        end else begin
            if (wr_zero) flags_word_zero_o <= mem_rd_data_i;
            if (wr_one)  flags_word_one_o  <= mem_rd_data_i;
            if (wr_fact) factor_reg_zero_o <= mem_rd_data_i;
            if (do_acc)  accum_o           <= accum_o + scaled;
            if (do_xfer) accum_o           <= product_i;
            if (set_auxp) aux_pointer_select_o <= cur_auxp;
        end
    end

    // Move of the fetched word one address up; address range is software's care
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mem_wr_o      <= 1'b0;
            mem_wr_addr_o <= '0;
            mem_wr_data_o <= '0;
        end else begin
            mem_wr_o <= do_move;
            if (do_move) begin
                mem_wr_addr_o <= cur_addr + OLAP_ADDR_W'(1);
                mem_wr_data_o <= mem_rd_data_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_fetch_apply;
        (state == OLAP_S_FETCH) ##1 (state == OLAP_S_APPLY);
    endsequence

    property p_flags_zero;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        wr_zero |=> (flags_word_zero_o == $past(mem_rd_data_i));
    endproperty
    a_flags_zero: assert property (p_flags_zero)
        else $error("flags word zero not loaded");

    property p_flags_sel;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (applying && is_n) |=> (cur_sel ? flags_word_one_o : flags_word_zero_o)
                               == $past(mem_rd_data_i);
    endproperty
    a_flags_sel: assert property (p_flags_sel)
        else $error("selected flags word not loaded");

    property p_flags_one;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (applying && cur_op == OLAP_OP_LOAD_FLAGS_ONE && !FIRST_GEN)
            |=> (flags_word_one_o == $past(mem_rd_data_i));
    endproperty
    a_flags_one: assert property (p_flags_one)
        else $error("flags word one not loaded");

    property p_factor;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (applying && cur_op == OLAP_OP_LOAD_FACTOR)
            |=> (factor_reg_zero_o == $past(mem_rd_data_i)) && $stable(accum_o);
    endproperty
    a_factor: assert property (p_factor)
        else $error("factor register not loaded");

    property p_accum;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        do_acc |=> (accum_o == $past(accum_o) + $past(scaled))
                   && (factor_reg_zero_o == $past(mem_rd_data_i));
    endproperty
    a_accum: assert property (p_accum)
        else $error("accumulate with load failed");

    property p_scale;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (do_acc && !FIRST_GEN && psm == 2'h2)
            |=> (accum_o == $past(accum_o) + ($past(product_i) << 4));
    endproperty
    a_scale: assert property (p_scale)
        else $error("product shift mode not applied");

    property p_move;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_fetch_apply ##0 (cur_op == OLAP_OP_ACCUM_MOVE))
            |=> mem_wr_o && (mem_wr_addr_o == $past(mem_rd_addr_o, 2) + 16'h0001)
                && (mem_wr_data_o == $past(mem_rd_data_i));
    endproperty
    a_move: assert property (p_move)
        else $error("data move to next address missing");

    property p_xfer;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        do_xfer |=> (accum_o == $past(product_i))
                    && (factor_reg_zero_o == $past(mem_rd_data_i));
    endproperty
    a_xfer: assert property (p_xfer)
        else $error("product transfer failed");

    property p_auxp;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (accept && op_indirect_i && auxp_new_en_i) ##2 1'b1
            |=> (aux_pointer_select_o == $past(auxp_new_i, 3));
    endproperty
    a_auxp: assert property (p_auxp)
        else $error("aux pointer not updated");

    property p_auxp_keep;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (applying && !set_auxp) |=> $stable(aux_pointer_select_o);
    endproperty
    a_auxp_keep: assert property (p_auxp_keep)
        else $error("aux pointer changed without request");

    property p_visible;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        accept |-> ##2 done_o ##1 op_ready_o;
    endproperty
    a_visible: assert property (p_visible)
        else $error("instruction did not complete in three cycles");

endmodule : olap_datapath

// ---- verification/olap_mem_model.sv ----
// Behavioural on-chip data RAM facing the datapath memory port.
// Assumes every read is answered the cycle after its strobe, with no wait states.
`timescale 1ns/1ps

module olap_mem_model (
    input  wire logic        sys_clk_i,
    input  wire logic        mem_rd_i,
    input  wire logic [15:0] rd_addr_i,
    output logic      [15:0] rd_data_o,
    input  wire logic        mem_wr_i,
    input  wire logic [15:0] wr_addr_i,
    input  wire logic [15:0] wr_data_i
);
    logic [15:0] ram [0:65535];

    // Every word holds its own address until written
    initial begin
        for (int a = 0; a < 65536; a++) ram[a] = a[15:0];
        rd_data_o = 16'h0000;
    end

    // Outside the answer cycle the data lines invert their previous value every cycle
    always @(posedge sys_clk_i) begin
        rd_data_o <= mem_rd_i ? ram[rd_addr_i] : ~rd_data_o;
        if (mem_wr_i) ram[wr_addr_i] <= wr_data_i;
    end
endmodule : olap_mem_model

// ---- verification/tb.sv ----
// Self-checking bench: later-generation datapath plus a first-generation twin.
// Assumes both share inputs and the memory model; all addresses are inside on-chip RAM.
`timescale 1ns/1ps

module tb;
    import olap_pkg::*;

    typedef struct packed {
        olap_op_e    op;
        logic        sel;
        logic        ind;
        logic [15:0] addr;
        logic [31:0] prod;
        logic [31:0] acc;
    } olap_row_s;

    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        op_valid  = 1'b0;
    olap_op_e    op_code   = OLAP_OP_LOAD_FLAGS;
    logic        flags_sel = 1'b0;
    logic        indirect  = 1'b0;
    logic        auxp_en   = 1'b0;
    logic [2:0]  auxp_new  = 3'h0;
    logic [15:0] addr      = 16'h0000;
    logic [31:0] product   = 32'h0000_0000;
    logic        ready, done, rd, wr;
    logic [15:0] rd_addr, rd_data, wr_addr, wr_data, f0, f1, t, g_f0, g_f1, g_t;
    logic [31:0] acc, g_acc;
    logic [2:0]  auxp;
    int          fails, num_checks, cyc, pulses;
    logic [15:0] ef0, ef1, et;
    logic [2:0]  eauxp;
    wire  [15:0] aux = indirect ? addr : ~addr;
    wire  [15:0] dir = indirect ? ~addr : addr;
    olap_row_s   rows [12] = '{
        '{OLAP_OP_LOAD_FLAGS,     1'b0, 1'b0, 16'h0110, 32'h0,        32'h0},
        '{OLAP_OP_LOAD_FLAGS_N,   1'b1, 1'b1, 16'h0300, 32'h0,        32'h0},
        '{OLAP_OP_ACCUM_PREV,     1'b0, 1'b0, 16'h0301, 32'h10,       32'h10},
        '{OLAP_OP_LOAD_FLAGS_ONE, 1'b0, 1'b1, 16'h0201, 32'h0,        32'h10},
        '{OLAP_OP_ACCUM_PREV,     1'b0, 1'b1, 16'h0302, 32'h10,       32'h30},
        '{OLAP_OP_LOAD_FLAGS_N,   1'b1, 1'b0, 16'h0202, 32'h0,        32'h30},
        '{OLAP_OP_ACCUM_MOVE,     1'b0, 1'b1, 16'h0303, 32'h10,       32'h130},
        '{OLAP_OP_LOAD_FLAGS_N,   1'b0, 1'b1, 16'h0403, 32'h0,        32'h130},
        '{OLAP_OP_LOAD_FLAGS_ONE, 1'b0, 1'b0, 16'h0203, 32'h0,        32'h130},
        '{OLAP_OP_ACCUM_PREV,     1'b0, 1'b0, 16'h0305, 32'h8000_0000, 32'hFE00_0130},
        '{OLAP_OP_PROD_TO_ACC,    1'b0, 1'b1, 16'h0306, 32'h1234_5678, 32'h1234_5678},
        '{OLAP_OP_LOAD_FACTOR,    1'b0, 1'b0, 16'h0307, 32'h0,        32'h1234_5678}};

    olap_datapath #(.FIRST_GEN(1'b0)) DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .op_valid_i(op_valid), .op_ready_o(ready), .op_code_i(op_code),
        .op_flags_sel_i(flags_sel), .op_indirect_i(indirect), .page_i(dir[15:7]),
        .page_ofs_i(dir[6:0]), .aux_addr_i(aux), .auxp_new_en_i(auxp_en),
        .auxp_new_i(auxp_new), .product_i(product), .done_o(done), .mem_rd_o(rd),
        .mem_rd_addr_o(rd_addr), .mem_rd_data_i(rd_data), .mem_wr_o(wr),
        .mem_wr_addr_o(wr_addr), .mem_wr_data_o(wr_data), .flags_word_zero_o(f0),
        .flags_word_one_o(f1), .factor_reg_zero_o(t), .accum_o(acc),
        .aux_pointer_select_o(auxp));
    olap_datapath #(.FIRST_GEN(1'b1)) DUT_G1 (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .op_valid_i(op_valid), .op_ready_o(), .op_code_i(op_code),
        .op_flags_sel_i(flags_sel), .op_indirect_i(indirect), .page_i(dir[15:7]),
        .page_ofs_i(dir[6:0]), .aux_addr_i(aux), .auxp_new_en_i(auxp_en),
        .auxp_new_i(auxp_new), .product_i(product), .done_o(), .mem_rd_o(),
        .mem_rd_addr_o(), .mem_rd_data_i(rd_data), .mem_wr_o(), .mem_wr_addr_o(),
        .mem_wr_data_o(), .flags_word_zero_o(g_f0), .flags_word_one_o(g_f1),
        .factor_reg_zero_o(g_t), .accum_o(g_acc), .aux_pointer_select_o());
    olap_mem_model mem (.sys_clk_i(sys_clk_i), .mem_rd_i(rd), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data), .mem_wr_i(wr), .wr_addr_i(wr_addr), .wr_data_i(wr_data));

    ////////////////////////////////////////////////////////////////////////////////
    initial forever #5 sys_clk_i = ~sys_clk_i;

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 1000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    // Called at a falling edge; returns at the falling edge of the result cycle
    task automatic run_op(input olap_row_s r, input int i);
        op_code = r.op;
        flags_sel = r.sel;
        indirect = r.ind;
        addr = r.addr;
        product = r.prod;
        auxp_new = 3'(i + 1);
        auxp_en = 1'b1;
        op_valid = 1'b1;
        @(negedge sys_clk_i);
        op_valid = 1'b0;
        check(32'({rd, ready}), 32'h2, "fetch strobe");
        check(32'(rd_addr), 32'(r.addr), "operand address");
        @(negedge sys_clk_i);
        check(32'(done), 32'h1, "done pulse");
        @(negedge sys_clk_i);
        check(32'(ready), 32'h1, "ready after done");
        check(32'(wr), 32'(r.op == OLAP_OP_ACCUM_MOVE), "move strobe");
        if (r.op == OLAP_OP_ACCUM_MOVE) begin
            check({wr_addr, wr_data}, {r.addr + 16'h1, r.addr}, "move");
        end
    endtask : run_op

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ef0 = 16'h0000;
        ef1 = 16'h0000;
        et = 16'h0000;
        eauxp = 3'h0;
        repeat (10) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        check(acc, 32'h0000_0000, "reset accumulator");
        check({f0, f1}, 32'h0000_0000, "reset flags words");
        check(32'({t, auxp, ready, done, rd, wr}), 32'h0000_0008, "reset outputs");
        for (int i = 0; i < 12; i++) begin
            run_op(rows[i], i);
            case (rows[i].op)
                OLAP_OP_LOAD_FLAGS:     ef0 = rows[i].addr;
                OLAP_OP_LOAD_FLAGS_N: begin
                    if (rows[i].sel) ef1 = rows[i].addr;
                    else ef0 = rows[i].addr;
                end
                OLAP_OP_LOAD_FLAGS_ONE: ef1 = rows[i].addr;
                default:                et = rows[i].addr;
            endcase
            if (rows[i].ind) eauxp = 3'(i + 1);
            check({f0, f1}, {ef0, ef1}, "flags words");
            check(32'(t), 32'(et), "factor reg");
            check(acc, rows[i].acc, "accumulator");
            check(32'(auxp), 32'(eauxp), "aux pointer");
        end
        check({g_f0, g_f1}, {16'h0110, 16'h0000}, "first gen flags");
        check(g_acc, 32'h8000_0030, "first gen accumulator");
        check(32'(g_t), 32'h0000_0307, "first gen factor reg");
        // Request held high while busy: only one take every third cycle
        op_code = OLAP_OP_LOAD_FACTOR;
        addr = 16'h0155;
        indirect = 1'b1;
        auxp_en = 1'b0;
        pulses = 0;
        op_valid = 1'b1;
        repeat (6) begin
            @(negedge sys_clk_i);
            pulses += int'(rd);
        end
        op_valid = 1'b0;
        check(32'(pulses), 32'h2, "takes while held");
        check(32'(t), 32'h0155, "factor after held request");
        check(32'(auxp), 32'(eauxp), "aux pointer kept");
        sys_rst_i = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        check(acc, 32'h0000_0000, "mid-run reset accumulator");
        check({f0, f1}, 32'h0000_0000, "mid-run reset flags words");
        check(32'({t, auxp, ready, done, rd, wr}), 32'h0000_0008, "mid-run reset outputs");
        give_verdict();
    end
endmodule : tb
